/* File: hw/imr_master.sv */
// imr_master.sv - two-wire master: repeated start, byte send, byte receive, ack
// Notes on behaviour
// R01 - restart begins only from idle sequencer
// R02 - pull clock, then load rate, release data
// R03 - timeout with data high releases clock
// R04 - data low, clock low, clear request
// R05 - start seen at once, flag at end
// R06 - restart request while busy is ignored
// R07 - collision: data low, or early clock low
// R08 - collision sets flag, port returns idle
// R09 - buffer write sets full, starts shifting
// R10 - data after fall, low then high periods
// R11 - after eighth fall clear full, release
// R12 - slave pulls data low to acknowledge
// R13 - ninth bit level goes to ack status
// R14 - after ninth clock flag, clock held low
// R15 - address is seven bits then direction
// R16 - write while busy dropped, sets collision
// R17 - receive request only accepted when idle
// R18 - toggle clock per rollover, shift data in
// R19 - eighth fall ends receive, buffer, flags
// R20 - full set on move, cleared on read
// R21 - byte done while full sets overflow
// R22 - software picks ack value, then acks
// R23 - ack: value out, low, release, low
// R24 - released clock waits until sampled high
// R25 - open-drain lines, decisions on sampled levels
`timescale 1ns/1ps
`include "imr_defs.svh"
module imr_master (
	// clock and reset
	input wire logic mclk_in,
	input wire logic arst_n_in,
	// bus lines, open drain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe_out,
	output logic sda_out,
	output logic sda_oe_out,
	// bit period reload
	input wire logic [7:0] rate_reload_value_in,
	// sequence requests, one-cycle pulses
	input wire logic restart_request_in,
	input wire logic receive_request_in,
	input wire logic ack_sequence_request_in,
	input wire logic ack_value_bit_in,
	// transmit buffer write
	input wire logic [7:0] tx_data_in,
	input wire logic tx_write_in,
	// receive stream out of the buffer
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	input wire logic rx_ready_in,
	// flag clears, one-cycle pulses
	input wire logic clear_irq_in,
	input wire logic clear_bus_collision_in,
	input wire logic clear_write_collision_in,
	input wire logic clear_overflow_in,
	// status
	output logic restart_request_out,
	output logic receive_request_out,
	output logic ack_sequence_request_out,
	output logic buffer_full_flag_out,
	output logic write_collision_flag_out,
	output logic receive_overflow_flag_out,
	output logic port_irq_flag_out,
	output logic bus_collision_flag_out,
	output logic slave_ack_status_out,
	output logic start_detected_out
);
	logic rst_meta_r, rst_n;
	logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
	imr_pkg::imr_state_t state_r, state_nxt;
	imr_pkg::imr_mode_t mode_r, mode_nxt;
	logic [7:0] brg_cnt_r, brg_cnt_nxt, shift_r, shift_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
	logic rs_busy_r, rs_busy_nxt, rx_busy_r, rx_busy_nxt, ack_busy_r, ack_busy_nxt;
	logic bf_r, bf_nxt, write_collision_flag_r, write_collision_flag_nxt, ovf_r, ovf_nxt, irq_r, irq_nxt;
	logic bcl_r, bcl_nxt, ackst_r, ackst_nxt, start_r, start_nxt;
	logic bf_set, bf_clr, irq_set, bcl_set, ovf_set, write_collision_flag_set;
	logic tick, push, pop, fifo_ready, tx_take;

	// bit-period counter only runs in timed phases
	function automatic logic is_timed(input imr_pkg::imr_state_t st);
		is_timed = (st == imr_pkg::IMR_LOW) || (st == imr_pkg::IMR_HIGH) ||
			(st == imr_pkg::IMR_HOLD);
	endfunction : is_timed

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// line sampling; the meta flops feed only the next stage
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_m_r <= scl_in;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	assign tick = is_timed(state_r) && (brg_cnt_r == `IMR_CNT_ZERO);
	assign pop = rx_valid_out && rx_ready_in;
	// a restart in the same cycle wins the idle slot
	assign tx_take = (state_r == imr_pkg::IMR_IDLE) && tx_write_in && !restart_request_in;

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		mode_nxt = mode_r;
		brg_cnt_nxt = brg_cnt_r;
		shift_nxt = shift_r;
		bit_nxt = bit_r;
		scl_oe_nxt = scl_oe_r;
		sda_oe_nxt = sda_oe_r;
		rs_busy_nxt = rs_busy_r;
		rx_busy_nxt = rx_busy_r;
		ack_busy_nxt = ack_busy_r;
		ackst_nxt = ackst_r;
		bf_set = 1'b0;
		bf_clr = pop; // R20
		irq_set = 1'b0;
		bcl_set = 1'b0;
		ovf_set = 1'b0;
		push = 1'b0;
		write_collision_flag_set = tx_write_in && !tx_take; // R16
		if (is_timed(state_r) && (brg_cnt_r != `IMR_CNT_ZERO)) begin
			brg_cnt_nxt = brg_cnt_r - `IMR_CNT_ONE;
		end
		case (state_r)
			imr_pkg::IMR_IDLE: begin
				if (restart_request_in) begin // R01 R06
					mode_nxt = imr_pkg::IMR_M_RS;
					rs_busy_nxt = 1'b1;
					scl_oe_nxt = 1'b1; // R02
					state_nxt = imr_pkg::IMR_PULL;
				end else if (tx_take) begin // R09
					mode_nxt = imr_pkg::IMR_M_TX;
					shift_nxt = tx_data_in;
					bit_nxt = `IMR_BIT_FIRST;
					bf_set = 1'b1;
					scl_oe_nxt = 1'b1;
					sda_oe_nxt = !tx_data_in[7]; // R15
					brg_cnt_nxt = rate_reload_value_in;
					state_nxt = imr_pkg::IMR_LOW;
				end else if (receive_request_in && fifo_ready) begin // R17
					mode_nxt = imr_pkg::IMR_M_RX;
					rx_busy_nxt = 1'b1;
					bit_nxt = `IMR_BIT_FIRST;
					scl_oe_nxt = 1'b1;
					sda_oe_nxt = 1'b0;
					brg_cnt_nxt = rate_reload_value_in;
					state_nxt = imr_pkg::IMR_LOW;
				end else if (ack_sequence_request_in) begin // R23
					mode_nxt = imr_pkg::IMR_M_ACK;
					ack_busy_nxt = 1'b1;
					scl_oe_nxt = 1'b1;
					sda_oe_nxt = !ack_value_bit_in;
					brg_cnt_nxt = rate_reload_value_in;
					state_nxt = imr_pkg::IMR_LOW;
				end
			end
			imr_pkg::IMR_PULL: begin
				sda_oe_nxt = 1'b0;
				if (!scl_s_r) begin // R02
					brg_cnt_nxt = rate_reload_value_in;
					state_nxt = imr_pkg::IMR_LOW;
				end
			end
			imr_pkg::IMR_LOW: begin
				if (tick) begin
					if ((mode_r != imr_pkg::IMR_M_RS) || sda_s_r) begin // R03
						scl_oe_nxt = 1'b0; // R10
						state_nxt = imr_pkg::IMR_REL;
					end else begin
						// data still held by someone: try another period
						brg_cnt_nxt = rate_reload_value_in;
					end
				end
			end
			imr_pkg::IMR_REL: begin
				if (scl_s_r) begin // R24
					brg_cnt_nxt = rate_reload_value_in;
					state_nxt = imr_pkg::IMR_HIGH;
					if ((mode_r == imr_pkg::IMR_M_RS) && !sda_s_r) begin // R07
						bcl_set = 1'b1;
					end
					if ((mode_r == imr_pkg::IMR_M_TX) && (bit_r == `IMR_BIT_ACK)) begin
						ackst_nxt = sda_s_r; // R13
					end
					if (mode_r == imr_pkg::IMR_M_RX) begin
						shift_nxt = {shift_r[6:0], sda_s_r}; // R18
					end
				end
			end
			imr_pkg::IMR_HIGH: begin
				if ((mode_r == imr_pkg::IMR_M_RS) && !scl_s_r) begin
					bcl_set = 1'b1; // R07
				end else if (tick) begin
					brg_cnt_nxt = rate_reload_value_in;
					scl_oe_nxt = 1'b1; // R10
					state_nxt = imr_pkg::IMR_LOW;
					case (mode_r)
						imr_pkg::IMR_M_RS: begin
							scl_oe_nxt = 1'b0;
							sda_oe_nxt = 1'b1; // R04
							state_nxt = imr_pkg::IMR_HOLD;
						end
						imr_pkg::IMR_M_TX: begin
							if (bit_r == `IMR_BIT_ACK) begin
								irq_set = 1'b1; // R14
								state_nxt = imr_pkg::IMR_IDLE;
							end else begin
								bit_nxt = bit_r + 4'h1;
								shift_nxt = {shift_r[6:0], 1'b0};
								if (bit_r == `IMR_BIT_LAST_DATA) begin
									bf_clr = 1'b1; // R11
									sda_oe_nxt = 1'b0;
								end else begin
									sda_oe_nxt = !shift_r[6];
								end
							end
						end
						imr_pkg::IMR_M_RX: begin
							if (bit_r == `IMR_BIT_LAST_DATA) begin // R19
								push = 1'b1;
								bf_set = 1'b1; // R20
								ovf_set = bf_r; // R21
								irq_set = 1'b1;
								rx_busy_nxt = 1'b0;
								state_nxt = imr_pkg::IMR_IDLE;
							end else begin
								bit_nxt = bit_r + 4'h1;
							end
						end
						default: begin
							irq_set = 1'b1; // R23
							ack_busy_nxt = 1'b0;
							state_nxt = imr_pkg::IMR_IDLE;
						end
					endcase
				end
			end
			imr_pkg::IMR_HOLD: begin
				if (tick) begin // R04
					scl_oe_nxt = 1'b1;
					rs_busy_nxt = 1'b0;
					irq_set = 1'b1; // R05
					state_nxt = imr_pkg::IMR_IDLE;
				end
			end
			default: begin
				state_nxt = imr_pkg::IMR_IDLE;
			end
		endcase
		if (bcl_set) begin // R08
			state_nxt = imr_pkg::IMR_IDLE;
			scl_oe_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
			rs_busy_nxt = 1'b0;
		end
		// sticky flags: a set in the clearing cycle wins
		bf_nxt = bf_set || (bf_r && !bf_clr);
		irq_nxt = irq_set || (irq_r && !clear_irq_in);
		bcl_nxt = bcl_set || (bcl_r && !clear_bus_collision_in);
		write_collision_flag_nxt = write_collision_flag_set || (write_collision_flag_r && !clear_write_collision_in);
		ovf_nxt = ovf_set || (ovf_r && !clear_overflow_in);
		// start seen on the lines; a stop clears it
		start_nxt = start_r;
		if (scl_s_r && scl_d_r && sda_d_r && !sda_s_r) begin // R05
			start_nxt = 1'b1;
		end else if (scl_s_r && scl_d_r && !sda_d_r && sda_s_r) begin
			start_nxt = 1'b0;
		end
	end

	// sequencer registers
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= imr_pkg::IMR_IDLE;
			mode_r <= imr_pkg::IMR_M_RS;
			brg_cnt_r <= `IMR_CNT_ZERO;
			shift_r <= 8'h00;
			bit_r <= `IMR_BIT_FIRST;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			rs_busy_r <= `IMR_FLAG_RESET;
			rx_busy_r <= `IMR_FLAG_RESET;
			ack_busy_r <= `IMR_FLAG_RESET;
			bf_r <= `IMR_FLAG_RESET;
			write_collision_flag_r <= `IMR_FLAG_RESET;
			ovf_r <= `IMR_FLAG_RESET;
			irq_r <= `IMR_FLAG_RESET;
			bcl_r <= `IMR_FLAG_RESET;
			ackst_r <= `IMR_FLAG_RESET;
			start_r <= `IMR_FLAG_RESET;
		end else begin
			state_r <= state_nxt;
			mode_r <= mode_nxt;
			brg_cnt_r <= brg_cnt_nxt;
			shift_r <= shift_nxt;
			bit_r <= bit_nxt;
			scl_oe_r <= scl_oe_nxt;
			sda_oe_r <= sda_oe_nxt;
			rs_busy_r <= rs_busy_nxt;
			rx_busy_r <= rx_busy_nxt;
			ack_busy_r <= ack_busy_nxt;
			bf_r <= bf_nxt;
			write_collision_flag_r <= write_collision_flag_nxt;
			ovf_r <= ovf_nxt;
			irq_r <= irq_nxt;
			bcl_r <= bcl_nxt;
			ackst_r <= ackst_nxt;
			start_r <= start_nxt;
		end
	end

	// received bytes queue here; a full queue refuses new receives
	imr_fifo #(.WIDTH(`IMR_DATA_W), .DEPTH(`IMR_FIFO_DEPTH), .AW(`IMR_FIFO_AW)) u_rx_fifo (
		.clk_in(mclk_in),
		.rst_n_in(rst_n),
		.in_valid_in(push),
		.in_ready_out(fifo_ready),
		.in_data_in(shift_nxt),
		.out_valid_out(rx_valid_out),
		.out_ready_in(rx_ready_in),
		.out_data_out(rx_data_out)
	);

	// open drain: level is always low, only the enables move
	assign scl_out = 1'b0; // R25
	assign sda_out = 1'b0;
	assign scl_oe_out = scl_oe_r;
	assign sda_oe_out = sda_oe_r;
	assign restart_request_out = rs_busy_r;
	assign receive_request_out = rx_busy_r;
	assign ack_sequence_request_out = ack_busy_r;
	assign buffer_full_flag_out = bf_r;
	assign write_collision_flag_out = write_collision_flag_r;
	assign receive_overflow_flag_out = ovf_r;
	assign port_irq_flag_out = irq_r;
	assign bus_collision_flag_out = bcl_r;
	assign slave_ack_status_out = ackst_r;
	assign start_detected_out = start_r;

	// checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n);
	a_restart_from_idle: assert property ($rose(rs_busy_r) |-> $past(state_r) == imr_pkg::IMR_IDLE) else $error("restart began while busy"); // R01
	a_restart_ignored: assert property ((state_r != imr_pkg::IMR_IDLE) && !rs_busy_r && restart_request_in |=> !rs_busy_r) else $error("restart taken while busy"); // R06
	a_pull_then_load: assert property ((state_r == imr_pkg::IMR_PULL) && !scl_s_r && !bcl_set |=> (state_r == imr_pkg::IMR_LOW) && (brg_cnt_r == $past(rate_reload_value_in)) && !sda_oe_r) else $error("no load after clock low"); // R02
	a_release_wait: assert property ((state_r == imr_pkg::IMR_REL) && !scl_s_r |=> (state_r == imr_pkg::IMR_REL) && !scl_oe_r) else $error("released clock not waited"); // R24
	a_restart_end: assert property ((state_r == imr_pkg::IMR_HOLD) && tick |=> scl_oe_r && sda_oe_r && !rs_busy_r && irq_r) else $error("restart end wrong"); // R04 R05
	a_collision_idle: assert property ($rose(bcl_r) |-> (state_r == imr_pkg::IMR_IDLE) && !scl_oe_r && !sda_oe_r) else $error("collision not idle"); // R07 R08
	a_write_collide: assert property (tx_write_in && (state_r != imr_pkg::IMR_IDLE) |=> write_collision_flag_r && (shift_r == $past(shift_r) || mode_r != imr_pkg::IMR_M_TX)) else $error("busy write not refused"); // R16
	a_tx_start: assert property (tx_take |=> bf_r && (state_r == imr_pkg::IMR_LOW) && (mode_r == imr_pkg::IMR_M_TX)) else $error("write did not start"); // R09
	a_ack_release: assert property ((mode_r == imr_pkg::IMR_M_TX) && (bit_r == `IMR_BIT_ACK) && (state_r == imr_pkg::IMR_LOW) |-> !sda_oe_r) else $error("data held in ack bit"); // R11
	a_rx_done: assert property ($fell(rx_busy_r) |-> bf_r && irq_r && scl_oe_r && (state_r == imr_pkg::IMR_IDLE)) else $error("receive end wrong"); // R19
	a_rx_from_idle: assert property ($rose(rx_busy_r) |-> $past(state_r) == imr_pkg::IMR_IDLE) else $error("receive began while busy"); // R17
	a_rx_overflow: assert property (push && bf_r |=> ovf_r) else $error("overflow missed"); // R21
	c_restart_done: cover property ((state_r == imr_pkg::IMR_HOLD) && tick);
	c_tx_nack: cover property ((mode_r == imr_pkg::IMR_M_TX) && (bit_r == `IMR_BIT_ACK) && irq_set && ackst_r);
	c_rx_byte: cover property (push);
	c_collision: cover property (bcl_set);
endmodule : imr_master

/* File: hw/imr_defs.svh */
// imr_defs.svh - constants of the two-wire master sequencer
`ifndef IMR_DEFS_SVH
`define IMR_DEFS_SVH
`define IMR_DATA_W 8
`define IMR_FIFO_DEPTH 16
`define IMR_FIFO_AW 4
`define IMR_BIT_FIRST 4'h0
`define IMR_BIT_LAST_DATA 4'h7
`define IMR_BIT_ACK 4'h8
`define IMR_CNT_ZERO 8'h00
`define IMR_CNT_ONE 8'h01
`define IMR_FLAG_RESET 1'b0
`endif

/* File: hw/imr_pkg.sv */
// imr_pkg.sv - types of the two-wire master sequencer
package imr_pkg;
	// phases of one sequence, gray along idle-pull-low-rel-high-hold
	typedef enum logic [2:0] {
		IMR_IDLE = 3'h0,
		IMR_PULL = 3'h1,
		IMR_LOW = 3'h3,
		IMR_REL = 3'h2,
		IMR_HIGH = 3'h6,
		IMR_HOLD = 3'h7
	} imr_state_t;
	// which sequence the phases belong to
	typedef enum logic [1:0] {
		IMR_M_RS = 2'h0,
		IMR_M_TX = 2'h1,
		IMR_M_RX = 2'h2,
		IMR_M_ACK = 2'h3
	} imr_mode_t;
endpackage : imr_pkg

/* File: hw/imr_fifo.sv */
// imr_fifo.sv - small receive fifo with registered read data
`timescale 1ns/1ps
`include "imr_defs.svh"
module imr_fifo #(
	parameter int WIDTH = `IMR_DATA_W,
	parameter int DEPTH = `IMR_FIFO_DEPTH,
	parameter int AW = `IMR_FIFO_AW
) (
	// clock and synchronised reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic out_valid_r, out_valid_nxt;
	logic [WIDTH-1:0] out_data_r, out_data_nxt;
	logic do_wr, do_rd;

	// memory holds DEPTH words; the output stage is one more
	assign in_ready_out = (cnt_r != DEPTH[AW:0]);
	assign out_valid_out = out_valid_r;
	assign out_data_out = out_data_r;

	// pointer and output-stage next values
	always_comb begin
		do_wr = in_valid_in && in_ready_out;
		do_rd = (cnt_r != '0) && (!out_valid_r || out_ready_in);
		wr_ptr_nxt = do_wr ? wr_ptr_r + 1'b1 : wr_ptr_r;
		rd_ptr_nxt = do_rd ? rd_ptr_r + 1'b1 : rd_ptr_r;
		cnt_nxt = cnt_r + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
		out_data_nxt = do_rd ? mem_r[rd_ptr_r] : out_data_r;
		out_valid_nxt = do_rd ? 1'b1 : (out_ready_in ? 1'b0 : out_valid_r);
	end

	// state registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
			out_valid_r <= 1'b0;
			out_data_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			cnt_r <= cnt_nxt;
			out_valid_r <= out_valid_nxt;
			out_data_r <= out_data_nxt;
		end
	end

	// storage needs no reset, only the pointers, count and output stage do
	always_ff @(posedge clk_in) begin
		if (do_wr) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end
endmodule : imr_fifo

/* File: tb/imr_slave_model.sv */
// imr_slave_model.sv - behavioural two-wire slave facing the master
`timescale 1ns/1ps
module imr_slave_model (
	// system clock, far faster than the bit rate
	input wire logic clk_in,
	// resolved bus lines
	input wire logic scl_in,
	input wire logic sda_in,
	// pulls, high = line driven low
	output logic scl_oe_out,
	output logic sda_oe_out,
	// behaviour commanded by the bench
	input wire logic ack_en_in,
	input wire logic reading_in,
	input wire logic [7:0] rd_byte_in,
	input wire logic [7:0] stretch_in,
	input wire logic jam_scl_in,
	// what the slave saw
	output logic [7:0] got_byte_out,
	output logic master_ack_out
);
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic [3:0] rise_cnt = 4'h0;
	logic [3:0] fall_cnt = 4'h0;
	logic [7:0] hold_cnt = 8'h00;

	// edge tracking; fall_cnt moves on falls and is cleared on a start, so apart from a start data never changes with the clock high
	always @(posedge clk_in) begin
		scl_q <= scl_in;
		sda_q <= sda_in;
		if (hold_cnt != 8'h00) begin
			hold_cnt <= hold_cnt - 8'h01;
		end
		if (scl_q && scl_in && sda_q && !sda_in) begin
			rise_cnt <= 4'h0; // start seen
			fall_cnt <= 4'h0;
		end else if (!scl_q && scl_in) begin
			rise_cnt <= rise_cnt + 4'h1;
			if (rise_cnt < 4'h8) begin
				got_byte_out <= {got_byte_out[6:0], sda_in};
			end
			if (rise_cnt == 4'h8) begin
				master_ack_out <= sda_in;
			end
		end else if (scl_q && !scl_in) begin
			fall_cnt <= (rise_cnt == 4'h9) ? 4'h0 : rise_cnt;
			rise_cnt <= (rise_cnt == 4'h9) ? 4'h0 : rise_cnt;
			hold_cnt <= stretch_in; // slow slave stretches the low phase
		end
	end

	// pulls: jam only when the bench asks for a collision
	assign scl_oe_out = jam_scl_in || (hold_cnt != 8'h00);
	assign sda_oe_out = reading_in ? (fall_cnt < 4'h8 && !rd_byte_in[3'h7 - fall_cnt[2:0]])
		: (fall_cnt == 4'h8 && ack_en_in);
endmodule : imr_slave_model

/* File: tb/tb_i2c_master_restart_tx_rx.sv */
// tb_i2c_master_restart_tx_rx.sv - self-checking bench of the two-wire master
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
	$display("FAIL t=%0t got %h want %h", $time, (a), (b)); end end
module tb_i2c_master_restart_tx_rx;
	logic mclk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic restart_request_in, receive_request_in, ack_sequence_request_in, ack_value_bit_in;
	logic [7:0] tx_data_in, rate_reload_value_in, rx_data_out, b, c, s_rd, s_stretch, s_got;
	logic tx_write_in, rx_ready_in, clear_irq_in, clear_bus_collision_in;
	logic clear_write_collision_in, clear_overflow_in, scl_out, sda_out, rx_valid_out;
	logic scl_oe_out, sda_oe_out, restart_request_out, receive_request_out;
	logic ack_sequence_request_out, buffer_full_flag_out, write_collision_flag_out;
	logic receive_overflow_flag_out, port_irq_flag_out, bus_collision_flag_out;
	logic slave_ack_status_out, start_detected_out;
	logic s_scl_oe, s_sda_oe, s_ack_en, s_reading, s_jam, s_mack;
	logic [7:0] q[$];
	int bad_count = 0;
	int tests_run = 0;
	int seed = 32'hbbea;
	int n;
	int i;
	// pull-ups: a line is low while any party pulls it
	wire scl_in = !(scl_oe_out || s_scl_oe);
	wire sda_in = !(sda_oe_out || s_sda_oe);

	imr_master u_imr_master (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .scl_in(scl_in),
		.sda_in(sda_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out),
		.sda_oe_out(sda_oe_out), .rate_reload_value_in(rate_reload_value_in),
		.restart_request_in(restart_request_in), .receive_request_in(receive_request_in),
		.ack_sequence_request_in(ack_sequence_request_in), .ack_value_bit_in(ack_value_bit_in),
		.tx_data_in(tx_data_in), .tx_write_in(tx_write_in), .rx_data_out(rx_data_out),
		.rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in), .clear_irq_in(clear_irq_in),
		.clear_bus_collision_in(clear_bus_collision_in),
		.clear_write_collision_in(clear_write_collision_in), .clear_overflow_in(clear_overflow_in),
		.restart_request_out(restart_request_out), .receive_request_out(receive_request_out),
		.ack_sequence_request_out(ack_sequence_request_out),
		.buffer_full_flag_out(buffer_full_flag_out),
		.write_collision_flag_out(write_collision_flag_out),
		.receive_overflow_flag_out(receive_overflow_flag_out),
		.port_irq_flag_out(port_irq_flag_out), .bus_collision_flag_out(bus_collision_flag_out),
		.slave_ack_status_out(slave_ack_status_out), .start_detected_out(start_detected_out));

	imr_slave_model u_imr_slave_model (.clk_in(mclk_in), .scl_in(scl_in), .sda_in(sda_in),
		.scl_oe_out(s_scl_oe), .sda_oe_out(s_sda_oe), .ack_en_in(s_ack_en),
		.reading_in(s_reading), .rd_byte_in(s_rd), .stretch_in(s_stretch),
		.jam_scl_in(s_jam), .got_byte_out(s_got), .master_ack_out(s_mack));

	// 20 MHz system clock
	initial begin
		forever #25 mclk_in = ~mclk_in;
	end

	task automatic tally_and_finish();
		$display("checks run %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	// one-cycle pulse on a request or clear input, driven just after the edge
	task automatic pulse(input int k);
		@(posedge mclk_in);
		#5;
		case (k)
			0: restart_request_in = 1'b1;
			1: tx_write_in = 1'b1;
			2: receive_request_in = 1'b1;
			3: ack_sequence_request_in = 1'b1;
			4: clear_irq_in = 1'b1;
			5: clear_write_collision_in = 1'b1;
			6: clear_bus_collision_in = 1'b1;
			default: clear_overflow_in = 1'b1;
		endcase
		@(posedge mclk_in);
		#5;
		{restart_request_in, tx_write_in, receive_request_in, ack_sequence_request_in,
			clear_irq_in, clear_write_collision_in, clear_bus_collision_in, clear_overflow_in} = '0;
	endtask : pulse

	// bounded wait for the end-of-sequence flag, then clear it
	task automatic finish_op();
		for (i = 0; i < 3000 && port_irq_flag_out !== 1'b1; i++) begin
			@(posedge mclk_in);
			#5;
		end
		`CHK(port_irq_flag_out, 1'b1)
		pulse(4);
	endtask : finish_op

	// one byte out, with refused requests thrown at the busy sequencer
	task automatic send(input logic [7:0] d, input logic ack);
		s_ack_en = ack;
		tx_data_in = d;
		pulse(1);
		`CHK(buffer_full_flag_out, 1'b1)
		pulse(0);
		`CHK(restart_request_out, 1'b0)
		pulse(1);
		`CHK(write_collision_flag_out, 1'b1)
		pulse(2);
		`CHK(receive_request_out, 1'b0)
		pulse(5);
		finish_op();
		`CHK(buffer_full_flag_out, 1'b0)
		`CHK(s_got, d)
		`CHK(slave_ack_status_out, !ack)
		`CHK({scl_oe_out, sda_oe_out}, 2'b10)
	endtask : send

	// one byte in, then the acknowledge chosen by software
	task automatic recv(input logic av);
		b = $random(seed);
		s_rd = b;
		pulse(2);
		if (receive_request_out === 1'b1) begin
			q.push_back(b);
			n++;
			finish_op();
			`CHK({buffer_full_flag_out, receive_request_out, scl_oe_out}, 3'b101)
			ack_value_bit_in = av;
			pulse(3);
			`CHK(ack_sequence_request_out, 1'b1)
			finish_op();
			`CHK({s_mack, ack_sequence_request_out}, {av, 1'b0})
		end
	endtask : recv

	// watchdog, well beyond the expected run of a few thousand cycles
	initial begin
		repeat (60000) @(posedge mclk_in);
		bad_count++;
		$display("FAIL t=%0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		{restart_request_in, receive_request_in, ack_sequence_request_in, ack_value_bit_in} = '0;
		{tx_data_in, tx_write_in, rx_ready_in, clear_irq_in, clear_bus_collision_in} = '0;
		{clear_write_collision_in, clear_overflow_in, s_ack_en, s_reading, s_jam} = '0;
		{s_rd, s_stretch} = '0;
		rate_reload_value_in = 8'h03;
		repeat (6) @(posedge mclk_in);
		#5;
		arst_n_in = 1'b1;
		repeat (3) @(posedge mclk_in);
		`CHK({scl_oe_out, sda_oe_out, port_irq_flag_out, bus_collision_flag_out}, 4'h0)
		`CHK({scl_out, sda_out}, 2'h0)
		// repeated start with a buffer write thrown at it while it runs
		pulse(0);
		`CHK(restart_request_out, 1'b1)
		pulse(1);
		`CHK(write_collision_flag_out, 1'b1)
		finish_op();
		`CHK(start_detected_out, 1'b1)
		`CHK({restart_request_out, scl_oe_out, sda_oe_out}, 3'b011)
		pulse(5);
		b = $random(seed);
		send({b[6:0], 1'b0}, 1'b1);
		for (n = 0; n < 4; n++) begin
			b = $random(seed);
			c = $random(seed);
			send(b, c[0]);
		end
		// slow slave stretching every low phase after the first
		s_stretch = 8'h14;
		send(8'hA5, 1'b1);
		s_stretch = 8'h00;
		// restart, read address, then fill the fifo until it refuses
		pulse(0);
		finish_op();
		send({b[6:0], 1'b1}, 1'b1);
		s_reading = 1'b1;
		n = 0;
		for (int j = 0; j < 20 && n == j; j++) begin
			c = $random(seed);
			recv(c[0]);
		end
		`CHK(n, 17)
		`CHK(receive_overflow_flag_out, 1'b1)
		pulse(7);
		// drain in order with the reader stalling at random
		for (int j = 0; j < 400 && q.size() > 0; j++) begin
			@(negedge mclk_in);
			if (rx_valid_out === 1'b1 && rx_ready_in === 1'b1) begin
				b = q.pop_front();
				`CHK(rx_data_out, b)
			end
			@(posedge mclk_in);
			#5;
			c = $random(seed);
			rx_ready_in = c[0];
		end
		rx_ready_in = 1'b0;
		`CHK({q.size() == 0, buffer_full_flag_out}, 2'b10)
		// another master holds the clock low during the high phase
		s_reading = 1'b0;
		rate_reload_value_in = 8'h0F;
		pulse(0);
		for (i = 0; i < 300 && scl_oe_out !== 1'b0; i++) begin
			@(posedge mclk_in);
			#5;
		end
		repeat (6) @(posedge mclk_in);
		#5;
		s_jam = 1'b1;
		for (i = 0; i < 300 && bus_collision_flag_out !== 1'b1; i++) begin
			@(posedge mclk_in);
			#5;
		end
		`CHK(bus_collision_flag_out, 1'b1)
		`CHK({scl_oe_out, sda_oe_out, restart_request_out}, 3'b000)
		s_jam = 1'b0;
		pulse(6);
		tally_and_finish();
	end
endmodule : tb_i2c_master_restart_tx_rx
